/* include/assil_pkg.sv */
// shared constants and types for the serial status and interrupt block
package assil_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [9:0] OFF_DATA = 10'h3F8;
	localparam logic [9:0] OFF_IE = 10'h3F9;
	localparam logic [9:0] OFF_IDENT = 10'h3FA;
	localparam logic [9:0] OFF_FORMAT = 10'h3FB;
	localparam logic [9:0] OFF_MODEM = 10'h3FC;
	localparam logic [9:0] OFF_LINE = 10'h3FD;
	localparam logic [9:0] OFF_MSTAT = 10'h3FE;

	// ****************************************
	// reset values and identification codes
	// ****************************************
	localparam logic [3:0] IE_RESET = 4'h0;
	localparam logic [4:0] MODEM_RESET = 5'h00;
	localparam logic [4:0] FORMAT_RESET = 5'h03;
	localparam logic [2:0] ID_NONE = 3'h1;
	localparam logic [2:0] ID_LINE = 3'h6;
	localparam logic [2:0] ID_DATA = 3'h4;
	localparam logic [2:0] ID_TX_HOLD_EMPTY_FLAG = 3'h2;
	localparam logic [2:0] ID_MODEM = 3'h0;

	// ****************************************
	// enable bit positions
	// ****************************************
	localparam int IE_DATA_BIT = 0;
	localparam int IE_TX_HOLD_EMPTY_FLAG_BIT = 1;
	localparam int IE_LINE_BIT = 2;
	localparam int IE_MODEM_BIT = 3;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 125000000;
	localparam int BAUD_HZ = 115200;
	localparam int OVERSAMPLE = 16;
	localparam int TICK_CYCLES = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
	localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
	localparam logic [3:0] PHASE_MID = 4'h7;
	localparam logic [3:0] PHASE_LAST = 4'hF;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic zero;
		logic tx_shifter_empty_flag;
		logic tx_hold_empty_flag;
		logic line_break_flag;
		logic stop_bit_error_flag;
		logic parity_mismatch_flag;
		logic overrun_flag;
		logic rx_char_ready;
	} assil_line_type;

	typedef struct packed {
		logic even_par;
		logic par_en;
		logic long_stop;
		logic [1:0] word_len;
	} assil_format_type;

	typedef struct packed {
		logic loop;
		logic aux2;
		logic aux1;
		logic rts;
		logic dtr;
	} assil_modem_type;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} assil_rx_type;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} assil_tx_type;

endpackage

/* core/assil_core.sv */
// serial adapter status, interrupt and modem output logic
// What this block does
// - set ready flag when character lands
// - ready clears on buffer read or zero write
// - overrun flag on unread overwrite, clear on read
// - parity mismatch flag, cleared by status read
// - stop-bit error when stop sampled low
// - break flag when low beyond char time
// - error flags raise line status source
// - hold empty set on transfer, cleared on load
// - shifter empty while idle, read only
// - line state top bit reads zero
// - four priority levels, line status highest
// - identification read freezes reported code
// - ident bit zero low when pending
// - ident bits two-one encode top source
// - ident upper five bits read zero
// - each source clears on its access
// - four enables gate sources onto output
// - all enables off inhibit interrupt and ident
// - enable upper four bits read zero
// - terminal ready output inverted from bit0
// - modem control five bits, rest zero
// - other modem outputs inverted likewise
// - loopback marks output, feeds receiver
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module assil_core
	import assil_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// serial line
	output logic serial_tx_line,
	input wire logic serial_rx_line,
	// modem side
	output logic dtr_n,
	output logic rts_n,
	output logic aux1_n,
	output logic aux2_n,
	input wire logic modem_change,
	output logic modem_status_rd,
	// interrupt
	output logic irq_out
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [3:0] data_bits(input logic [1:0] wl);
		data_bits = 4'd5 + {2'b00, wl};
	endfunction

	function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl, input logic even);
		logic [7:0] m;
		m = d & (8'hFF >> (3'd3 - {1'b0, wl}));
		par_of = even ? ^m : ~^m;
	endfunction

	// ****************************************
	// state
	// ****************************************
	assil_line_type line_state;
	assil_format_type fmt;
	assil_modem_type modem_output_control;
	logic [3:0] interrupt_enable;
	logic [7:0] rx_buffer_reg;
	logic [7:0] tx_hold_reg;
	logic tx_hold_empty_flag_int;
	logic [6:0] tick_cnt;
	logic baud_tick;
	assil_rx_type rx_state;
	logic [3:0] rx_ph;
	logic [2:0] rx_idx;
	logic [7:0] rx_data;
	logic rx_par;
	logic [7:0] low_cnt;
	assil_tx_type tx_state;
	logic [5:0] tx_ph;
	logic [2:0] tx_idx;
	logic [7:0] tx_shift;
	logic tx_bit;

	// ****************************************
	// register decode
	// ****************************************
	wire rd_rbr = rd && addr == OFF_DATA;
	wire wr_thr = wr && addr == OFF_DATA;
	wire wr_ie = wr && addr == OFF_IE;
	wire rd_iir = rd && addr == OFF_IDENT;
	wire wr_fmt = wr && addr == OFF_FORMAT;
	wire wr_mcr = wr && addr == OFF_MODEM;
	wire rd_lsr = rd && addr == OFF_LINE;
	wire wr_lsr = wr && addr == OFF_LINE;
	assign modem_status_rd = rd && addr == OFF_MSTAT;

	// ****************************************
	// baud tick divider
	// ****************************************
	assign baud_tick = tick_cnt == TICK_LAST;
	always_ff @(posedge core_clk) begin
		if (rst || baud_tick) begin
			tick_cnt <= 7'h00;
		end else begin
			tick_cnt <= tick_cnt + 7'h01;
		end
	end

	// ****************************************
	// receiver
	// ****************************************
	wire [3:0] nbits = data_bits(fmt.word_len);
	// loopback feeds the shifter back in
	wire rx_in = modem_output_control.loop ? tx_bit : serial_rx_line;
	wire rx_done = rx_state == RX_STOP && baud_tick && rx_ph == PHASE_LAST;
	wire [7:0] char_ticks = {nbits + 4'd2 + {3'b000, fmt.par_en} + {3'b000, fmt.long_stop}, 4'h0};
	// low for longer than a whole character
	wire bi_evt = baud_tick && !rx_in && low_cnt == char_ticks;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_state <= RX_IDLE;
			rx_ph <= 4'h0;
			rx_idx <= 3'h0;
			rx_data <= 8'h00;
			rx_par <= 1'b0;
		end else if (baud_tick) begin
			rx_ph <= rx_ph + 4'h1;
			case (rx_state)
				RX_IDLE: begin
					rx_ph <= 4'h0;
					// only a fresh fall starts a frame, so a long break gives one character, not a train
					if (!rx_in && low_cnt == 8'h00) begin
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					if (rx_ph == PHASE_MID) begin
						rx_ph <= 4'h0;
						rx_idx <= 3'h0;
						rx_data <= 8'h00;
						rx_state <= rx_in ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_ph == PHASE_LAST) begin
						rx_data[rx_idx] <= rx_in;
						rx_idx <= rx_idx + 3'h1;
						if ({1'b0, rx_idx} == nbits - 4'd1) begin
							rx_state <= fmt.par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_ph == PHASE_LAST) begin
						rx_par <= rx_in;
						rx_state <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_ph == PHASE_LAST) begin
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// break counter saturates so the flag is raised once per low stretch
	always_ff @(posedge core_clk) begin
		if (rst || rx_in) begin
			low_cnt <= 8'h00;
		end else if (baud_tick && low_cnt != 8'hFF) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_buffer_reg <= 8'h00;
		end else if (rx_done) begin
			rx_buffer_reg <= rx_data;
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	// hold write wins the cycle, the shifter takes the char one later
	wire tx_take = tx_state == TX_IDLE && !line_state.tx_hold_empty_flag && !wr_thr;
	wire [5:0] stop_ticks = !fmt.long_stop ? 6'd16 : (fmt.word_len == 2'b00 ? 6'd24 : 6'd32);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_ph <= 6'h00;
			tx_idx <= 3'h0;
			tx_shift <= 8'h00;
		end else if (tx_take) begin
			tx_shift <= tx_hold_reg;
			tx_state <= TX_START;
			tx_ph <= 6'h00;
			tx_idx <= 3'h0;
		end else if (baud_tick && tx_state != TX_IDLE) begin
			tx_ph <= tx_ph + 6'h01;
			if (tx_state == TX_STOP) begin
				if (tx_ph == stop_ticks - 6'd1) begin
					tx_state <= TX_IDLE;
				end
			end else if (tx_ph[3:0] == PHASE_LAST) begin
				tx_ph <= 6'h00;
				case (tx_state)
					TX_START: tx_state <= TX_DATA;
					TX_DATA: begin
						tx_idx <= tx_idx + 3'h1;
						if ({1'b0, tx_idx} == nbits - 4'd1) begin
							tx_state <= fmt.par_en ? TX_PAR : TX_STOP;
						end
					end
					default: tx_state <= TX_STOP;
				endcase
			end
		end
	end

	always_comb begin
		case (tx_state)
			TX_START: tx_bit = 1'b0;
			TX_DATA: tx_bit = tx_shift[tx_idx];
			TX_PAR: tx_bit = par_of(tx_shift, fmt.word_len, fmt.even_par);
			default: tx_bit = 1'b1;
		endcase
	end

	// line held at marking during loopback
	always_ff @(posedge core_clk) begin
		if (rst) begin
			serial_tx_line <= 1'b1;
		end else begin
			serial_tx_line <= modem_output_control.loop | tx_bit;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_hold_reg <= 8'h00;
		end else if (wr_thr) begin
			tx_hold_reg <= wdata;
		end
	end

	// ****************************************
	// line state flags
	// ****************************************
	wire rx_pe = fmt.par_en && rx_par != par_of(rx_data, fmt.word_len, fmt.even_par);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			line_state <= '0;
		end else begin
			// new character sets ready; read or zero write clears
			if (rx_done) begin
				line_state.rx_char_ready <= 1'b1;
			end else if (rd_rbr || (wr_lsr && !wdata[0])) begin
				line_state.rx_char_ready <= 1'b0;
			end
			if (rx_done && line_state.rx_char_ready) begin
				line_state.overrun_flag <= 1'b1;
			end else if (rd_lsr) begin
				line_state.overrun_flag <= 1'b0;
			end
			if (rx_done && rx_pe) begin
				line_state.parity_mismatch_flag <= 1'b1;
			end else if (rd_lsr) begin
				line_state.parity_mismatch_flag <= 1'b0;
			end
			if (rx_done && !rx_in) begin
				line_state.stop_bit_error_flag <= 1'b1;
			end else if (rd_lsr) begin
				line_state.stop_bit_error_flag <= 1'b0;
			end
			// break flag set by long spacing
			if (bi_evt) begin
				line_state.line_break_flag <= 1'b1;
			end else if (rd_lsr) begin
				line_state.line_break_flag <= 1'b0;
			end
			// set on transfer, cleared on load
			if (wr_thr) begin
				line_state.tx_hold_empty_flag <= 1'b0;
			end else if (tx_take) begin
				line_state.tx_hold_empty_flag <= 1'b1;
			end
		end
		if (rst) begin
			line_state.tx_hold_empty_flag <= 1'b1;
		end
	end

	logic line_state_shifter;
	assign line_state_shifter = tx_state == TX_IDLE;

	// ****************************************
	// interrupt sources and identification
	// ****************************************
	// any error flag raises line status
	wire src_line = line_state.overrun_flag | line_state.parity_mismatch_flag
		| line_state.stop_bit_error_flag | line_state.line_break_flag;
	wire pend_line = interrupt_enable[IE_LINE_BIT] & src_line;
	wire pend_data = interrupt_enable[IE_DATA_BIT] & line_state.rx_char_ready;
	wire pend_tx_hold_empty_flag = interrupt_enable[IE_TX_HOLD_EMPTY_FLAG_BIT] & tx_hold_empty_flag_int;
	wire pend_modem = interrupt_enable[IE_MODEM_BIT] & modem_change;
	// all enables off gives no pending source
	wire any_pend = pend_line | pend_data | pend_tx_hold_empty_flag | pend_modem;
	// fixed priority; bit0 low when pending; source code
	wire [2:0] id_code = pend_line ? ID_LINE : pend_data ? ID_DATA : pend_tx_hold_empty_flag ? ID_TX_HOLD_EMPTY_FLAG
		: pend_modem ? ID_MODEM : ID_NONE;

	// transmit source cleared by its reporting read or a load
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_hold_empty_flag_int <= 1'b0;
		end else if (tx_take) begin
			tx_hold_empty_flag_int <= 1'b1;
		end else if (wr_thr || (rd_iir && id_code == ID_TX_HOLD_EMPTY_FLAG)) begin
			tx_hold_empty_flag_int <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= any_pend;
		end
	end

	// ****************************************
	// control registers and modem outputs
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			interrupt_enable <= IE_RESET;
			modem_output_control <= MODEM_RESET;
			fmt <= FORMAT_RESET;
		end else begin
			if (wr_ie) begin
				interrupt_enable <= wdata[3:0];
			end
			if (wr_mcr) begin
				modem_output_control <= wdata[4:0];
			end
			if (wr_fmt) begin
				fmt <= wdata[4:0];
			end
		end
	end

	assign dtr_n = ~modem_output_control.dtr;
	assign rts_n = ~modem_output_control.rts;
	assign aux1_n = ~modem_output_control.aux1;
	assign aux2_n = ~modem_output_control.aux2;

	// ****************************************
	// read data
	// ****************************************
	// top bit zero; shifter bit read only
	wire [7:0] lsr_view = {1'b0, line_state_shifter, line_state[5:0]};
	// code frozen into read data in the read cycle; zero fill
	wire [7:0] read_value = rd_rbr ? rx_buffer_reg : rd && addr == OFF_IE ? {4'h0, interrupt_enable}
		: rd_iir ? {5'h00, id_code} : rd && addr == OFF_FORMAT ? {3'h0, fmt}
		: rd && addr == OFF_MODEM ? {3'h0, modem_output_control} : rd_lsr ? lsr_view : 8'h00;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= read_value;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	ready_set_a: assert property (rx_done |=> line_state.rx_char_ready) else $error("ready not set");
	ready_clear_a: assert property (rd_rbr && !rx_done |=> !line_state.rx_char_ready)
		else $error("ready not cleared");
	overrun_set_a: assert property (rx_done && line_state.rx_char_ready |=> line_state.overrun_flag)
		else $error("overrun missed");
	error_clear_a: assert property (rd_lsr && !rx_done && !bi_evt |=> !src_line)
		else $error("errors not cleared");
	hold_load_a: assert property (wr_thr |=> !line_state.tx_hold_empty_flag ##1 !line_state_shifter)
		else $error("hold load wrong");
	shift_take_a: assert property (tx_take |=> !line_state_shifter && line_state.tx_hold_empty_flag)
		else $error("transfer flags wrong");
	ident_bit_a: assert property (rd_iir |=> rdata[0] == !$past(any_pend) && rdata[7:3] == 5'h00)
		else $error("ident bit0 wrong");
	ident_top_a: assert property (rd_iir && pend_line |=> rdata == 8'h06)
		else $error("line status not top");
	irq_follow_a: assert property (any_pend |=> irq_out) else $error("irq not raised");
	irq_off_a: assert property (interrupt_enable == 4'h0 |=> !irq_out) else $error("irq not inhibited");
	dtr_write_a: assert property (wr_mcr |=> dtr_n == !$past(wdata[0])) else $error("dtr wrong");
	loop_mark_a: assert property (modem_output_control.loop |=> serial_tx_line)
		else $error("loop not marking");

	rx_char_c: cover property (rx_done ##1 line_state.rx_char_ready);
	tx_take_c: cover property (wr_thr ##1 tx_take);
	break_c: cover property (bi_evt);
	tx_hold_empty_flag_ident_c: cover property (rd_iir && id_code == ID_TX_HOLD_EMPTY_FLAG);

endmodule
`default_nettype wire

/* verif/assil_modem_model.sv */
// modem side partner: serial frames in both directions and a status change source
`timescale 1ns/1ps
`default_nettype none
module assil_modem_model
	import assil_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial line
	input wire logic serial_tx_line,
	output logic serial_rx_line,
	// modem status
	output logic modem_change,
	input wire logic modem_status_rd
);
	// ****************************************
	// line drive and capture
	// ****************************************
	localparam int BIT_CYC = TICK_CYCLES * 16;
	logic [7:0] got_q[$];
	logic [7:0] shift;

	initial begin
		serial_rx_line = 1'b1;
		modem_change = 1'b0;
	end

	task automatic hold_line(input logic lvl, input int bits);
		serial_rx_line <= lvl;
		repeat (bits * BIT_CYC) @(posedge core_clk);
	endtask

	// odd parity; bad_par and stop_lvl spoil the frame only when a test asks
	task automatic send_char(input logic [7:0] data, input logic par_en, input logic bad_par, input logic stop_lvl);
		hold_line(1'b0, 1);
		for (int i = 0; i < 8; i++) begin
			hold_line(data[i], 1);
		end
		if (par_en) begin
			hold_line(~(^data) ^ bad_par, 1);
		end
		hold_line(stop_lvl, 1);
		hold_line(1'b1, 1);
	endtask

	task automatic raise_change();
		modem_change <= 1'b1;
	endtask

	// change stays pending until the status read pulse, as outside logic would
	always @(posedge core_clk) begin
		if (rst || modem_status_rd) begin
			modem_change <= 1'b0;
		end
	end

	// receiver knows the reset format only: 8 data bits, no parity
	initial begin
		forever begin
			@(negedge serial_tx_line);
			repeat (BIT_CYC + BIT_CYC / 2) @(posedge core_clk);
			for (int i = 0; i < 8; i++) begin
				shift[i] = serial_tx_line;
				repeat (BIT_CYC) @(posedge core_clk);
			end
			got_q.push_back(shift);
		end
	end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the serial status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import assil_pkg::*;
;
	// ****************************************
	// bench signals
	// ****************************************
	localparam int BIT_CYC = TICK_CYCLES * 16;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] addr = 10'h000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic serial_tx_line, serial_rx_line, dtr_n, rts_n, aux1_n, aux2_n, modem_change, modem_status_rd, irq_out;
	int error_cnt = 0;
	int num_checks = 0;

	always #4 core_clk = ~core_clk;

	assil_core i_dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line), .dtr_n(dtr_n), .rts_n(rts_n),
		.aux1_n(aux1_n), .aux2_n(aux2_n), .modem_change(modem_change), .modem_status_rd(modem_status_rd),
		.irq_out(irq_out));

	assil_modem_model i_modem (.core_clk(core_clk), .rst(rst), .serial_tx_line(serial_tx_line),
		.serial_rx_line(serial_rx_line), .modem_change(modem_change), .modem_status_rd(modem_status_rd));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// strobe dropped and one edge passed, so the next call never re-drives it in the same step
	task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd_chk(input string what, input logic [9:0] a, input logic [7:0] mask, input logic [7:0] exp);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		check(what, rdata & mask, exp);
		@(posedge core_clk);
	endtask

	task automatic wait_irq(input logic lvl, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (irq_out !== lvl && n < lim);
		check("irq_out", 8'(irq_out), 8'(lvl));
		@(posedge core_clk);
	endtask

	task automatic close_out();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rd_chk("line_state", OFF_LINE, 8'hFF, 8'h60);
		rd_chk("interrupt_ident", OFF_IDENT, 8'hFF, 8'h01);
		rd_chk("interrupt_enable", OFF_IE, 8'hFF, 8'h00);
		check("modem pins", 8'({dtr_n, rts_n, aux1_n, aux2_n}), 8'h0F);
	endtask

	task automatic t_regs();
		reg_wr(OFF_IE, 8'hFF);
		rd_chk("interrupt_enable", OFF_IE, 8'hFF, 8'h0F);
		wait_irq(1'b0, 4);
		reg_wr(OFF_IE, 8'h00);
		reg_wr(OFF_MODEM, 8'hEF);
		rd_chk("modem_output_control", OFF_MODEM, 8'hFF, 8'h0F);
		check("modem pins all set", 8'({dtr_n, rts_n, aux1_n, aux2_n}), 8'h00);
		reg_wr(OFF_MODEM, 8'h05);
		check("modem pins mixed", 8'({dtr_n, rts_n, aux1_n, aux2_n}), 8'h05);
		reg_wr(OFF_MODEM, 8'h00);
		rd_chk("unmapped", 10'h000, 8'hFF, 8'h00);
	endtask

	task automatic t_tx();
		int n;
		n = 0;
		reg_wr(OFF_IE, 8'h02);
		reg_wr(OFF_DATA, 8'hA5);
		wait_irq(1'b1, 6);
		rd_chk("ident tx empty", OFF_IDENT, 8'hFF, 8'h02);
		rd_chk("ident after report", OFF_IDENT, 8'hFF, 8'h01);
		wait_irq(1'b0, 4);
		reg_wr(OFF_DATA, 8'h5A);
		rd_chk("line both busy", OFF_LINE, 8'hFF, 8'h00);
		while (i_modem.got_q.size() < 2 && n < 30 * BIT_CYC) begin
			@(posedge core_clk);
			n++;
		end
		check("first tx char", i_modem.got_q[0], 8'hA5);
		check("second tx char", i_modem.got_q[1], 8'h5A);
		repeat (BIT_CYC) @(posedge core_clk);
		wait_irq(1'b1, 4);
		rd_chk("line idle", OFF_LINE, 8'hFF, 8'h60);
		rd_chk("ident tx empty", OFF_IDENT, 8'hFF, 8'h02);
	endtask

	task automatic t_rx();
		reg_wr(OFF_FORMAT, 8'h0B);
		reg_wr(OFF_IE, 8'h0F);
		i_modem.send_char(8'h3C, 1'b1, 1'b0, 1'b1);
		wait_irq(1'b1, 10);
		rd_chk("ident data", OFF_IDENT, 8'hFF, 8'h04);
		rd_chk("line ready", OFF_LINE, 8'hFF, 8'h61);
		i_modem.send_char(8'h81, 1'b1, 1'b1, 1'b0);
		repeat (10) @(posedge core_clk);
		rd_chk("ident line status", OFF_IDENT, 8'hFF, 8'h06);
		rd_chk("line errors", OFF_LINE, 8'hFF, 8'h6F);
		rd_chk("line errors cleared", OFF_LINE, 8'hFF, 8'h61);
		rd_chk("ident back to data", OFF_IDENT, 8'hFF, 8'h04);
		rd_chk("rx buffer", OFF_DATA, 8'hFF, 8'h81);
		rd_chk("line after read", OFF_LINE, 8'hFF, 8'h60);
		wait_irq(1'b0, 4);
	endtask

	task automatic t_break();
		i_modem.hold_line(1'b0, 14);
		i_modem.hold_line(1'b1, 4);
		rd_chk("break and ready", OFF_LINE, 8'h11, 8'h11);
		reg_wr(OFF_LINE, 8'h00);
		rd_chk("ready after zero write", OFF_LINE, 8'h01, 8'h00);
		rd_chk("break char", OFF_DATA, 8'hFF, 8'h00);
		rd_chk("ident idle", OFF_IDENT, 8'hFF, 8'h01);
	endtask

	task automatic t_loop();
		logic went_low;
		went_low = 1'b0;
		reg_wr(OFF_FORMAT, 8'h03);
		reg_wr(OFF_MODEM, 8'h10);
		i_modem.hold_line(1'b0, 0);
		reg_wr(OFF_DATA, 8'h5A);
		repeat (12 * BIT_CYC) begin
			@(posedge core_clk);
			#1;
			if (serial_tx_line !== 1'b1) begin
				went_low = 1'b1;
			end
		end
		check("looped output low", 8'(went_low), 8'h00);
		@(posedge core_clk);
		i_modem.hold_line(1'b1, 0);
		wait_irq(1'b1, 4);
		reg_wr(OFF_IE, 8'h00);
		wait_irq(1'b0, 4);
		rd_chk("ident inhibited", OFF_IDENT, 8'hFF, 8'h01);
		rd_chk("line while inhibited", OFF_LINE, 8'h11, 8'h01);
		rd_chk("looped char", OFF_DATA, 8'hFF, 8'h5A);
		reg_wr(OFF_MODEM, 8'h00);
	endtask

	task automatic t_modem();
		i_modem.raise_change();
		reg_wr(OFF_IE, 8'h0A);
		wait_irq(1'b1, 4);
		rd_chk("ident tx over modem", OFF_IDENT, 8'hFF, 8'h02);
		rd_chk("ident modem", OFF_IDENT, 8'hFF, 8'h00);
		rd_chk("modem status read", OFF_MSTAT, 8'hFF, 8'h00);
		check("modem change served", 8'(modem_change), 8'h00);
		wait_irq(1'b0, 4);
		rd_chk("ident none", OFF_IDENT, 8'hFF, 8'h01);
	endtask

	// ****************************************
	// sequence and watchdog
	// ****************************************
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_regs();
		t_tx();
		t_rx();
		t_break();
		t_loop();
		t_modem();
		close_out();
	end

	// about 80k cycles expected; serial frames dominate
	initial begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		close_out();
	end
endmodule
`default_nettype wire
